// [inc/sleep_pkg.sv]
// shared types and constants for the sleep and wake-up controller
// assumes a single 250 MHz system clock and a core that strobes its events
package sleep_pkg;
	localparam int CLK_MHZ = 250;
	localparam int WATCH_PINS = 4;
	// watchdog nominal period, in microseconds, unprescaled
	localparam int WDT_PERIOD_US = 18000;
	localparam int WDT_PERIOD_CYCLES = WDT_PERIOD_US * CLK_MHZ;
	// device reset timer periods, in microseconds
	localparam int DRT_POR_US = 18000;
	localparam int DRT_SHORT_US = 300;
	localparam int DRT_POR_CYCLES = DRT_POR_US * CLK_MHZ;
	localparam int DRT_SHORT_CYCLES = DRT_SHORT_US * CLK_MHZ;
	localparam int PRESCALE_MAX_LOG2 = 7;
	// status bit positions within the status byte
	localparam int STATUS_TIMEOUT_BIT = 4;
	localparam int STATUS_POWERDOWN_BIT = 3;
	localparam int STATUS_WAKE_BIT = 7;
	// flag values on power-up
	localparam logic FLAG_TIMEOUT_RESET = 1'h1;
	localparam logic FLAG_POWERDOWN_RESET = 1'h1;
	localparam logic FLAG_WAKE_RESET = 1'h0;

	typedef enum logic [1:0] {
		RUN_STATE = 2'h0,
		SLEEP_STATE = 2'h1,
		RESET_STATE = 2'h3
	} power_state_type;

	typedef struct packed {
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic pin_change_wake_flag;
	} status_flags_type;

	typedef struct packed {
		logic wdt_enable;
		logic reset_pin_is_reset;
		logic wake_on_change_enable;
		logic prescaler_to_wdt;
		logic [2:0] prescale_select;
		logic short_drt;
	} config_type;
endpackage

// [logic/sync2.sv]
// two-flop synchroniser for a bus of asynchronous levels
// assumes the inputs come from pins outside the clock domain
`timescale 1ns/100ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stage <= '0;
			sync_out <= '0;
		end else begin
			stage <= async_in;
			sync_out <= stage;
		end
	end
endmodule

// [logic/reset_timer.sv]
// down counter that holds the core in reset until it expires
// assumes start is a one-cycle pulse; restart while running reloads
`timescale 1ns/100ps
module reset_timer #(
	parameter int WIDTH = 24
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [WIDTH-1:0] load_value,
	output logic busy
);
	logic [WIDTH-1:0] count;
	wire logic done = (count == '0);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			busy <= 1'b0;
		end else if (start) begin
			count <= load_value;
			busy <= 1'b1;
		end else if (!done) begin
			count <= count - 1'b1;
			busy <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
		end else begin
			busy <= 1'b0;
		end
	end
endmodule

// [logic/sleep_wakeup_control.sv]
// power-down entry and wake-up control: sleep entry, watchdog, flags,
// pin-change wake, reset generation.
// assumes reset_n is power-on reset; core strobes are on clk_sys.
//
// Behaviour
// RULE1 - executing the sleep instruction puts the device into power-down.
// RULE2 - sleep entry clears an enabled watchdog, which keeps counting.
// RULE3 - sleep entry sets the active-low timeout flag, status bit 4.
// RULE4 - sleep entry clears the active-low power-down flag, status bit 3.
// RULE5 - sleep entry stops the oscillator driver until wake-up.
// RULE6 - pins keep their pre-sleep drive state while asleep.
// RULE7 - watchdog reset is internal and never pulls the reset pin low.
// RULE8 - wake on reset pin, watchdog timeout, or watched pin change.
// RULE9 - every wake-up causes a full device reset.
// RULE10 - watchdog wake-up clears the timeout flag.
// RULE11 - power-down flag set on power-up, cleared only by sleep.
// RULE12 - pin-change wake flag set when a watched pin changes in sleep.
// RULE13 - in sleep, compare watched pins with last port read reference.
// RULE14 - stale change from earlier wake causes immediate wake next sleep.
// RULE15 - software should read watched pins just before sleeping.
// RULE16 - any wake-up clears the watchdog counter.
// RULE17 - reset pin pulse leaves all three flags unchanged; a reset-pin wake here clears the pin-change wake flag.
// RULE18 - watchdog timeout also starts the device reset timer.
// RULE19 - sleep clears the prescaler when it is assigned to the watchdog.
// RULE20 - each port read captures watched pins as comparison reference; the code captures only on a port read in the run state.
`timescale 1ns/100ps
module sleep_wakeup_control
	import sleep_pkg::*;
#(
	parameter int WDT_CYCLES = WDT_PERIOD_CYCLES,
	parameter int DRT_LONG_CYCLES = DRT_POR_CYCLES,
	parameter int DRT_SHORT = DRT_SHORT_CYCLES
) (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// core strobes
	input wire logic sleep_exec,
	input wire logic clear_watchdog,
	input wire logic port_read,
	// configuration
	input wire config_type cfg,
	// pins
	input wire logic shared_reset_input_pin,
	input wire logic wake_pin_0,
	input wire logic wake_pin_1,
	input wire logic wake_pin_3,
	input wire logic wake_pin_4,
	// port drive state from the core
	input wire logic [WATCH_PINS-1:0] port_out_in,
	input wire logic [WATCH_PINS-1:0] port_oe_in,
	// pin drive
	output logic [WATCH_PINS-1:0] port_out,
	output logic [WATCH_PINS-1:0] port_oe,
	output logic external_reset_pin_n_oe,
	// status and control
	output status_flags_type status_flags,
	output logic [7:0] status_byte,
	output logic osc_enable,
	output logic core_reset,
	output logic asleep,
	output logic watchdog_timeout
);
	localparam int CW = 32;
	localparam int TW = 32;

	power_state_type state;
	logic [CW-1:0] watchdog_counter;
	logic [PRESCALE_MAX_LOG2-1:0] prescaler;
	logic [WATCH_PINS-1:0] pin_reference;
	logic [WATCH_PINS-1:0] pins_sync;
	logic reset_pin_sync;
	logic reset_pin_prev;
	logic drt_start;
	logic [TW-1:0] drt_load;
	logic drt_busy;
	logic first_drt_done;

	sync2 #(.WIDTH(WATCH_PINS + 1)) pin_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in({shared_reset_input_pin, wake_pin_4, wake_pin_3, wake_pin_1, wake_pin_0}),
		.sync_out({reset_pin_sync, pins_sync})
	);

	reset_timer #(.WIDTH(TW)) device_reset_timer (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(drt_start),
		.load_value(drt_load),
		.busy(drt_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	wire logic in_sleep = (state == SLEEP_STATE);
	wire logic sleep_take = (state == RUN_STATE) && sleep_exec && !drt_busy;
	wire logic [PRESCALE_MAX_LOG2:0] pre_mask =
		(PRESCALE_MAX_LOG2 + 1)'((1 << cfg.prescale_select) - 1);
	wire logic pre_tick = !cfg.prescaler_to_wdt ||
		((prescaler & pre_mask[PRESCALE_MAX_LOG2-1:0]) == pre_mask[PRESCALE_MAX_LOG2-1:0]);
	wire logic wdt_wrap = cfg.wdt_enable && (watchdog_counter == CW'(WDT_CYCLES - 1));
	wire logic wdt_fire = wdt_wrap && pre_tick;
	// mismatch includes a stale change never re-read: reference is old [RULE13] [RULE14]
	wire logic pin_mismatch = |(pins_sync ^ pin_reference);
	wire logic change_wake = in_sleep && cfg.wake_on_change_enable && pin_mismatch; // [RULE8]
	wire logic pin_reset_fall = cfg.reset_pin_is_reset && reset_pin_prev && !reset_pin_sync;
	wire logic pin_wake = in_sleep && pin_reset_fall; // [RULE8]
	wire logic wdt_wake = in_sleep && wdt_fire; // [RULE8]
	wire logic any_wake = pin_wake || wdt_wake || change_wake;
	// watchdog is restarted on sleep entry and on every wake [RULE2] [RULE16]
	wire logic wdt_clear = clear_watchdog || sleep_take || any_wake;
	// device reset timer starts on wake and on a watchdog timeout [RULE18]
	assign drt_start = any_wake || wdt_fire;
	assign drt_load = (cfg.short_drt && first_drt_done) ?
		TW'(DRT_SHORT) : TW'(DRT_LONG_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// power state

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= RESET_STATE;
		end else begin
			unique case (state)
				RUN_STATE: begin
					if (sleep_take) begin
						state <= SLEEP_STATE; // [RULE1]
					end else if (wdt_fire) begin
						state <= RESET_STATE;
					end
				end
				SLEEP_STATE: begin
					if (any_wake) begin
						state <= RESET_STATE; // full reset, no resume [RULE9]
					end
				end
				RESET_STATE: begin
					if (!drt_busy && !drt_start) begin
						state <= RUN_STATE;
					end
				end
				default: state <= RESET_STATE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			first_drt_done <= 1'b0;
		end else if (state == RESET_STATE && !drt_busy && !drt_start) begin
			first_drt_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog and its prescaler; the watchdog keeps counting on clk_sys in sleep

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_counter <= '0;
		end else if (wdt_clear || !cfg.wdt_enable || wdt_wrap) begin
			watchdog_counter <= '0;
		end else begin
			watchdog_counter <= watchdog_counter + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prescaler <= '0;
		end else if (cfg.prescaler_to_wdt && (wdt_clear || wdt_fire)) begin
			prescaler <= '0; // [RULE19]
		end else if (wdt_wrap) begin
			prescaler <= prescaler + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			// matches the synchroniser's reset level: no false fall after reset
			reset_pin_prev <= 1'b0;
		end else begin
			reset_pin_prev <= reset_pin_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// change reference, captured on each port read in the run state

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_reference <= '0;
		end else if (port_read && state == RUN_STATE) begin
			pin_reference <= pins_sync; // [RULE20]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags; a reset pin pulse in run leaves them alone, a reset-pin wake clears the wake flag [RULE17]

	wire logic next_timeout_n = wdt_fire ? 1'b0 : // [RULE10]
		(sleep_take || clear_watchdog) ? 1'b1 : status_flags.timeout_flag_n; // [RULE3]
	wire logic next_powerdown_n = sleep_take ? 1'b0 : // [RULE4] [RULE11]
		clear_watchdog ? 1'b1 : status_flags.powerdown_flag_n;
	// set wins over any clear: only a wake or watchdog reset redefines it
	wire logic next_wake_flag = change_wake ? 1'b1 : // [RULE12]
		(wdt_fire || pin_wake) ? 1'b0 : status_flags.pin_change_wake_flag;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_flags.timeout_flag_n <= FLAG_TIMEOUT_RESET;
			status_flags.powerdown_flag_n <= FLAG_POWERDOWN_RESET; // [RULE11]
			status_flags.pin_change_wake_flag <= FLAG_WAKE_RESET;
		end else begin
			status_flags.timeout_flag_n <= next_timeout_n;
			status_flags.powerdown_flag_n <= next_powerdown_n;
			status_flags.pin_change_wake_flag <= next_wake_flag;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_byte <= 8'h18;
		end else begin
			status_byte <= 8'h00;
			status_byte[STATUS_TIMEOUT_BIT] <= next_timeout_n;
			status_byte[STATUS_POWERDOWN_BIT] <= next_powerdown_n;
			status_byte[STATUS_WAKE_BIT] <= next_wake_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	wire logic next_asleep = (state == SLEEP_STATE && !any_wake) || sleep_take;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			port_out <= '0;
			port_oe <= '0;
			osc_enable <= 1'b1;
			core_reset <= 1'b1;
			asleep <= 1'b0;
			watchdog_timeout <= 1'b0;
			external_reset_pin_n_oe <= 1'b0;
		end else begin
			// drive state frozen while asleep [RULE6]
			if (!next_asleep) begin
				port_out <= port_out_in;
				port_oe <= port_oe_in;
			end
			osc_enable <= !next_asleep; // [RULE5]
			asleep <= next_asleep;
			core_reset <= drt_start || drt_busy || (state == RESET_STATE); // [RULE9] [RULE18]
			watchdog_timeout <= wdt_fire;
			external_reset_pin_n_oe <= 1'b0; // never driven [RULE7]
		end
	end
endmodule

// [verification/sleep_props.sv]
// port assertions for the sleep and wake-up controller
// assumes a bind from the bench top; one clock domain
`timescale 1ns/100ps
module sleep_props
	import sleep_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// watched ports
	input wire logic sleep_exec,
	input wire logic core_reset,
	input wire logic asleep,
	input wire logic osc_enable,
	input wire logic watchdog_timeout,
	input wire logic external_reset_pin_n_oe,
	input wire logic [WATCH_PINS-1:0] port_out,
	input wire logic [WATCH_PINS-1:0] port_oe,
	input wire status_flags_type status_flags,
	input wire logic [7:0] status_byte
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence sleep_taken;
		sleep_exec && !core_reset && !asleep;
	endsequence
	sequence wake_seen;
		asleep ##1 !asleep;
	endsequence
	sleep_entry_a: assert property (sleep_taken |=> asleep && !osc_enable)
		else $error("sleep not entered");
	sleep_flags_a: assert property (sleep_taken |=> status_flags.timeout_flag_n
		&& !status_flags.powerdown_flag_n) else $error("flags wrong on sleep");
	osc_off_a: assert property (asleep |-> !osc_enable)
		else $error("oscillator on while asleep");
	pins_frozen_a: assert property (asleep && $past(asleep) |-> $stable(port_out)
		&& $stable(port_oe)) else $error("pins moved while asleep");
	pin_released_a: assert property (external_reset_pin_n_oe == 1'h0)
		else $error("reset pin driven");
	wake_reset_a: assert property (wake_seen |-> core_reset)
		else $error("wake without reset");
	wdt_flag_a: assert property (watchdog_timeout && $past(asleep)
		|-> !status_flags.timeout_flag_n) else $error("timeout flag kept");
	pd_clear_a: assert property ($fell(status_flags.powerdown_flag_n) |-> $past(sleep_exec))
		else $error("power-down flag cleared without sleep");
	status_map_a: assert property (status_byte == {status_flags.pin_change_wake_flag,
		2'h0, status_flags.timeout_flag_n, status_flags.powerdown_flag_n, 3'h0})
		else $error("status byte map");
	wdt_drt_a: assert property (watchdog_timeout |-> ##[0:2] core_reset)
		else $error("timeout without reset timer");
endmodule

// [verification/pin_partner.sv]
// behavioural model of the reset pin and the four watched pins
// assumes the bench asks for levels; pins move off the clock edge
`timescale 1ns/100ps
module pin_partner (
	// clock and requests
	input wire logic clk_sys,
	input wire logic hold_n,
	input wire logic [3:0] flip,
	// pins
	output logic reset_pin,
	output logic [3:0] wake_pins
);
	initial begin
		reset_pin = 1'h1;
		wake_pins = 4'h5;
	end
	// late settling keeps the pins unrelated to the sampling edge
	always @(posedge clk_sys) begin
		reset_pin <= #1.3 hold_n;
		wake_pins <= #1.3 4'h5 ^ flip;
	end
endmodule

// [verification/sleep_wakeup_control_test.sv]
// self-checking bench for the sleep and wake-up controller
// assumes short watchdog and reset timer counts given below
`timescale 1ns/100ps
module sleep_wakeup_control_test;
	import sleep_pkg::*;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic sleep_exec = 1'h0;
	logic clear_watchdog = 1'h0;
	logic port_read = 1'h0;
	logic hold_n = 1'h1;
	logic [3:0] flip = 4'h0;
	config_type cfg = '0;
	logic [3:0] port_out_in = 4'h0;
	logic [3:0] port_oe_in = 4'h0;
	logic reset_pin;
	logic [3:0] wp, port_out, port_oe;
	logic ext_oe, osc_enable, core_reset, asleep, watchdog_timeout;
	status_flags_type status_flags;
	logic [7:0] status_byte, hold;
	logic [7:0] notes[$];
	logic pa = 1'h0;
	logic pc = 1'h1;
	logic [31:0] seed = 32'h5C;
	int fails = 0;
	int n_tests = 0;
	int waited;
	always #2 clk_sys = ~clk_sys;
	pin_partner partner (.clk_sys(clk_sys), .hold_n(hold_n), .flip(flip),
		.reset_pin(reset_pin), .wake_pins(wp));
	sleep_wakeup_control #(.WDT_CYCLES(50), .DRT_LONG_CYCLES(40), .DRT_SHORT(10)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .sleep_exec(sleep_exec),
		.clear_watchdog(clear_watchdog), .port_read(port_read), .cfg(cfg),
		.shared_reset_input_pin(reset_pin), .wake_pin_0(wp[0]), .wake_pin_1(wp[1]),
		.wake_pin_3(wp[2]), .wake_pin_4(wp[3]), .port_out_in(port_out_in),
		.port_oe_in(port_oe_in), .port_out(port_out), .port_oe(port_oe),
		.external_reset_pin_n_oe(ext_oe), .status_flags(status_flags),
		.status_byte(status_byte), .osc_enable(osc_enable), .core_reset(core_reset),
		.asleep(asleep), .watchdog_timeout(watchdog_timeout));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// 0 sleep, 1 port read, 2 clear watchdog
	task automatic pulse(input int which);
		@(negedge clk_sys);
		sleep_exec = (which == 0);
		port_read = (which == 1);
		clear_watchdog = (which == 2);
		@(negedge clk_sys);
		{sleep_exec, port_read, clear_watchdog} = 3'h0;
	endtask
	// s 1 waits for asleep low, s 0 for core_reset low
	task automatic wait_for(input logic s, input int lim);
		waited = 0;
		while ((s ? asleep : core_reset) !== 1'h0) begin
			@(negedge clk_sys);
			waited++;
			if (waited > lim) begin
				fails++;
				$display("wait ran out at %0t", $time);
				end_of_test();
			end
		end
	endtask
	task automatic go_sleep(input logic [7:0] exp, input logic [7:0] after);
		notes.push_back(exp);
		notes.push_back(after);
		pulse(0);
	endtask
	////////////////////////////////////////////////////////////////
	// a result is sleep entry or the end of a device reset
	always @(negedge clk_sys) begin
		if ((asleep === 1'h1 && !pa) || (core_reset === 1'h0 && pc)) begin
			check(status_byte, notes.size() ? notes.pop_front() : 8'hEE);
		end
		pa = (asleep === 1'h1);
		pc = (core_reset !== 1'h0);
	end
	initial begin
		notes.push_back(8'h18);
		repeat (20) @(negedge clk_sys);
		reset_n = 1'h1;
		wait_for(1'h0, 100);
		cfg.wake_on_change_enable = 1'h1;
		pulse(1);
		go_sleep(8'h10, 8'h90);
		hold = {port_out, port_oe};
		repeat (4) begin
			seed = xs(seed);
			{port_out_in, port_oe_in} = seed[7:0];
			@(negedge clk_sys);
			check({port_out, port_oe}, hold);
		end
		flip = 4'h2;
		wait_for(1'h1, 20);
		check({7'h0, core_reset}, 8'h01);
		wait_for(1'h0, 100);
		$display("pin-change wake done");
		go_sleep(8'h90, 8'h90);
		wait_for(1'h1, 8);
		wait_for(1'h0, 100);
		$display("stale reference wake done");
		cfg.wake_on_change_enable = 1'h0;
		cfg.wdt_enable = 1'h1;
		pulse(2);
		pulse(1);
		repeat (30) @(negedge clk_sys);
		go_sleep(8'h90, 8'h00);
		wait_for(1'h1, 80);
		check({7'h0, waited >= 40}, 8'h01);
		cfg.wdt_enable = 1'h0;
		wait_for(1'h0, 100);
		$display("watchdog wake done");
		cfg.reset_pin_is_reset = 1'h1;
		pulse(1);
		go_sleep(8'h10, 8'h10);
		hold_n = 1'h0;
		wait_for(1'h1, 20);
		hold_n = 1'h1;
		wait_for(1'h0, 100);
		hold_n = 1'h0;
		repeat (6) @(negedge clk_sys);
		hold_n = 1'h1;
		repeat (6) @(negedge clk_sys);
		check(status_byte, 8'h10);
		$display("reset pin wake done");
		end_of_test();
	end
endmodule
bind sleep_wakeup_control sleep_props props (.clk_sys(clk_sys), .reset_n(reset_n),
	.sleep_exec(sleep_exec), .core_reset(core_reset), .asleep(asleep),
	.osc_enable(osc_enable), .watchdog_timeout(watchdog_timeout),
	.external_reset_pin_n_oe(external_reset_pin_n_oe), .port_out(port_out),
	.port_oe(port_oe), .status_flags(status_flags), .status_byte(status_byte));
